// ==== rtl/efm_accum.sv ====
`include "efm_defs.svh"

module efm_accum (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic reseed,
  input wire logic exact,
  input wire efm_pkg::efm_word_t frac_word,
  input wire efm_pkg::efm_step_t step_count,
  input wire efm_pkg::efm_step_t residue,
  input wire efm_pkg::efm_word_t seed,
  output efm_pkg::efm_word_t acc_q,
  output logic carry_q,
  output logic step_q
);
  import efm_pkg::*;

  efm_acc_s s_q;
  efm_acc_s s_d;
  logic [`EFM_STEP_BITS:0] aux_sum;
  logic dec;
  logic [`EFM_MOD_BITS:0] sum;

  always_comb
  begin
    s_d = s_q;
    s_d.step = 1'b0;
    // Second accumulator spreads the ceiling excess r/M over M ticks,
    // so the 24-bit modulus stays whole while the mean is exact
    aux_sum = {1'b0, s_q.aux} + {1'b0, residue};
    dec = exact && (aux_sum >= {1'b0, step_count});
    sum = {1'b0, s_q.acc} + {1'b0, frac_word} - {{`EFM_MOD_BITS{1'b0}}, dec};
    if (tick)
      s_d.step = 1'b1;
    // Reload does not wait for the mode: a modulator switched on at
    // this tick must still start from the seed
    if (reseed)
    begin
      s_d.acc = seed;
      s_d.aux = '0;
      s_d.carry = 1'b0;
    end
    else if (tick)
    begin
      s_d.acc = sum[`EFM_MOD_BITS-1:0];
      s_d.carry = sum[`EFM_MOD_BITS];
      s_d.aux = dec ? aux_sum[`EFM_STEP_BITS-1:0] - step_count
                    : aux_sum[`EFM_STEP_BITS-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign acc_q = s_q.acc;
  assign carry_q = s_q.carry;
  assign step_q = s_q.step;

endmodule : efm_accum

// ==== rtl/efm_defs.svh ====
// Notes on behaviour
// - Modulator word is 24 bits wide
// - Modulus is fixed binary, never configurable
// - Exact mode keeps full 24-bit accumulator
// - Plain fractional mode exact only for binary fractions
// - Exact mode needs step count below 2^14
// - Step count reprogrammable or fixed for channels
// - Fractional needs enable set, bypass cleared
// - Fractional integer ratio held in 20..524284
// - New fractional word reloads the seed
`ifndef EFM_DEFS_SVH
`define EFM_DEFS_SVH

// ****************************************
// Register addresses
// ****************************************
`define EFM_ADDR_W 5
`define EFM_ADDR_INT 5'h03
`define EFM_ADDR_FRAC 5'h04
`define EFM_ADDR_CFG 5'h06
`define EFM_ADDR_STEP 5'h0C
`define EFM_ADDR_STAT 5'h10
`define EFM_ADDR_ACC 5'h11

// ****************************************
// Field widths and positions
// ****************************************
`define EFM_MOD_BITS 24
`define EFM_INT_BITS 19
`define EFM_STEP_BITS 14
`define EFM_DATA_W 24
`define EFM_CFG_FRAC_EN 11
`define EFM_CFG_BYPASS 7
`define EFM_CFG_SEED_LO 0

// ****************************************
// Limits and reset values
// ****************************************
`define EFM_INT_MIN 19'h00014
`define EFM_INT_MAX 19'h7FFFC
`define EFM_INT_RST 19'h00014
`define EFM_FRAC_RST 24'h000000
`define EFM_STEP_RST 14'h0000
`define EFM_SEED0 24'h000000
`define EFM_SEED1 24'h800000
`define EFM_SEED2 24'hB29D2B
`define EFM_SEED3 24'h50F5A1
`define EFM_SEED_RST 2'h2

`endif

// ==== rtl/efm_pkg.sv ====
`include "efm_defs.svh"

package efm_pkg;

  typedef logic [`EFM_MOD_BITS-1:0] efm_word_t;
  typedef logic [`EFM_STEP_BITS-1:0] efm_step_t;
  typedef logic [`EFM_INT_BITS-1:0] efm_int_t;

  typedef struct packed {
    efm_word_t acc;
    efm_step_t aux;
    logic carry;
    logic step;
  } efm_acc_s;

  typedef struct packed {
    efm_int_t int_sh;
    efm_word_t frac_sh;
    efm_step_t step_sh;
    logic frac_en_sh;
    logic bypass_sh;
    logic [1:0] seed_sh;
    efm_int_t int_act;
    efm_word_t frac_act;
    efm_step_t step_act;
    efm_step_t res_act;
    logic frac_mode;
    logic exact_mode;
    logic [1:0] seed_act;
    logic pend;
    logic reseed_pend;
    logic [`EFM_INT_BITS:0] div;
    logic div_vld;
    logic ratio_err;
    logic [`EFM_DATA_W-1:0] rdata;
  } efm_top_s;

endpackage : efm_pkg

// ==== rtl/efm_top.sv ====
`include "efm_defs.svh"

module efm_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pd_tick,
  input wire logic reg_we,
  input wire logic [`EFM_ADDR_W-1:0] reg_addr,
  input wire logic [`EFM_DATA_W-1:0] reg_wdata,
  output logic [`EFM_DATA_W-1:0] reg_rdata,
  output logic [`EFM_INT_BITS:0] div_ratio,
  output logic div_valid,
  output logic frac_active,
  output logic exact_active,
  output logic ratio_err
);
  import efm_pkg::*;

  efm_top_s s_q;
  efm_top_s s_d;
  efm_word_t acc;
  logic acc_carry;
  logic acc_step;
  efm_word_t seed_val;
  logic exact;
  logic [`EFM_MOD_BITS+`EFM_STEP_BITS-1:0] prod;
  logic [`EFM_DATA_W-1:0] rd_mux;
  logic apply;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic efm_int_t clamp_int(input efm_int_t n);
    if (n < `EFM_INT_MIN)
      return `EFM_INT_MIN;
    else if (n > `EFM_INT_MAX)
      return `EFM_INT_MAX;
    else
      return n;
  endfunction : clamp_int

  // Fractional window only; integer mode is not limited here
  function automatic logic out_of_range(input efm_int_t n);
    return (n < `EFM_INT_MIN) || (n > `EFM_INT_MAX);
  endfunction : out_of_range

  function automatic efm_word_t seed_sel(input logic [1:0] code);
    case (code)
      2'h0: return `EFM_SEED0;
      2'h1: return `EFM_SEED1;
      2'h2: return `EFM_SEED2;
      default: return `EFM_SEED3;
    endcase
  endfunction : seed_sel

  // ****************************************
  // Modulator accumulator
  // ****************************************
  // Zero step count means plain binary fractions only
  assign exact = s_q.exact_mode;
  assign seed_val = seed_sel(s_q.seed_act);
  assign apply = pd_tick && s_q.pend;

  // A pending seed code is the one used at the applying tick
  efm_accum u_accum (
    .clk(clk),
    .rstn(rstn),
    .tick(pd_tick && s_q.frac_mode),
    .reseed(apply && s_q.reseed_pend),
    .exact(exact),
    .frac_word(s_q.frac_act),
    .step_count(s_q.step_act),
    .residue(s_q.res_act),
    .seed(apply ? seed_sel(s_q.seed_sh) : seed_val),
    .acc_q(acc),
    .carry_q(acc_carry),
    .step_q(acc_step)
  );

  // Excess of the rounded-up word: frac*M mod 2^14 (low 14 product bits), always below M
  assign prod = s_q.frac_sh * s_q.step_sh;

  // ****************************************
  // Register read mux
  // ****************************************
  always_comb
  begin
    rd_mux = '0;
    if (reg_addr == `EFM_ADDR_INT)
      rd_mux = {5'h00, s_q.int_sh};
    else if (reg_addr == `EFM_ADDR_FRAC)
      rd_mux = s_q.frac_sh;
    else if (reg_addr == `EFM_ADDR_CFG)
    begin
      rd_mux[`EFM_CFG_FRAC_EN] = s_q.frac_en_sh;
      rd_mux[`EFM_CFG_BYPASS] = s_q.bypass_sh;
      rd_mux[`EFM_CFG_SEED_LO+1:`EFM_CFG_SEED_LO] = s_q.seed_sh;
    end
    else if (reg_addr == `EFM_ADDR_STEP)
      rd_mux = {10'h000, s_q.step_sh};
    else if (reg_addr == `EFM_ADDR_STAT)
      rd_mux = {20'h00000, s_q.pend, s_q.ratio_err, exact, s_q.frac_mode};
    else if (reg_addr == `EFM_ADDR_ACC)
      rd_mux = acc;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    s_d.div_vld = 1'b0;
    s_d.rdata = rd_mux;

    // ****************************************
    // Apply at comparison tick
    // ****************************************
    // Words take effect only at a comparison tick, so a half-written
    // set of words never reaches the divider mid-cycle
    if (apply)
    begin
      s_d.int_act = s_q.int_sh;
      s_d.frac_act = s_q.frac_sh;
      s_d.step_act = s_q.step_sh;
      s_d.res_act = prod[`EFM_STEP_BITS-1:0];
      s_d.frac_mode = s_q.frac_en_sh && !s_q.bypass_sh;
      // Own flop, so the pin never lags the mode by a cycle
      s_d.exact_mode = s_d.frac_mode && (s_q.step_sh != '0);
      s_d.seed_act = s_q.seed_sh;
      s_d.pend = 1'b0;
      s_d.reseed_pend = 1'b0;
    end

    // ****************************************
    // Register writes
    // ****************************************
    // Writes land in the shadow set; a write in the apply cycle stays pending
    if (reg_we)
    begin
      if (reg_addr == `EFM_ADDR_INT)
      begin
        s_d.int_sh = reg_wdata[`EFM_INT_BITS-1:0];
        s_d.pend = 1'b1;
      end
      else if (reg_addr == `EFM_ADDR_FRAC)
      begin
        s_d.frac_sh = reg_wdata;
        s_d.pend = 1'b1;
        s_d.reseed_pend = 1'b1;
      end
      else if (reg_addr == `EFM_ADDR_CFG)
      begin
        s_d.frac_en_sh = reg_wdata[`EFM_CFG_FRAC_EN];
        s_d.bypass_sh = reg_wdata[`EFM_CFG_BYPASS];
        s_d.seed_sh = reg_wdata[`EFM_CFG_SEED_LO+1:`EFM_CFG_SEED_LO];
        s_d.pend = 1'b1;
        s_d.reseed_pend = 1'b1;
      end
      else if (reg_addr == `EFM_ADDR_STEP)
      begin
        s_d.step_sh = reg_wdata[`EFM_STEP_BITS-1:0];
        s_d.pend = 1'b1;
      end
    end

    // ****************************************
    // Divider word
    // ****************************************
    // Flag follows the mode and word in force after this edge, so
    // leaving fractional mode never leaves a stale flag for a cycle
    s_d.ratio_err = s_d.frac_mode && out_of_range(s_d.int_act);

    // Integer mode passes the word untouched; fractional clamps it
    if (s_q.frac_mode)
    begin
      if (acc_step)
      begin
        s_d.div = {1'b0, clamp_int(s_q.int_act)}
                  + {{`EFM_INT_BITS{1'b0}}, acc_carry};
        s_d.div_vld = 1'b1;
      end
    end
    else
    begin
      if (pd_tick)
      begin
        // The applying tick already divides by the new word
        s_d.div = {1'b0, apply ? s_q.int_sh : s_q.int_act};
        s_d.div_vld = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.int_sh <= `EFM_INT_RST;
      s_q.int_act <= `EFM_INT_RST;
      s_q.frac_sh <= `EFM_FRAC_RST;
      s_q.frac_act <= `EFM_FRAC_RST;
      s_q.step_sh <= `EFM_STEP_RST;
      s_q.step_act <= `EFM_STEP_RST;
      s_q.seed_sh <= `EFM_SEED_RST;
      s_q.seed_act <= `EFM_SEED_RST;
    end
    else
      s_q <= s_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = s_q.rdata;
  assign div_ratio = s_q.div;
  assign div_valid = s_q.div_vld;
  assign frac_active = s_q.frac_mode;
  assign exact_active = s_q.exact_mode;
  assign ratio_err = s_q.ratio_err;

endmodule : efm_top

// ==== tb/efm_check_sva.sv ====
// ****************************************
// Port-level checks of the modulator block
// ****************************************
module efm_check (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pd_tick,
  input wire logic reg_we,
  input wire logic [4:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  input wire logic [19:0] div_ratio,
  input wire logic div_valid,
  input wire logic frac_active,
  input wire logic exact_active,
  input wire logic ratio_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Config write, one quiet cycle, then the applying tick
  sequence s_cfg(logic on);
    (reg_we && reg_addr == 5'h06 && ((reg_wdata[11] && !reg_wdata[7]) == on))
      ##1 !reg_we ##1 (pd_tick && !reg_we);
  endsequence
  property p_frac_on;
    s_cfg(1'b1) |=> frac_active;
  endproperty
  property p_frac_off;
    s_cfg(1'b0) |=> !frac_active && !exact_active;
  endproperty
  property p_int_valid;
    (pd_tick && !frac_active) ##1 !frac_active |-> div_valid;
  endproperty
  property p_frac_valid;
    (pd_tick && frac_active) ##1 frac_active |=> div_valid;
  endproperty
  property p_valid_cause;
    div_valid |-> $past(pd_tick) || $past(pd_tick, 2);
  endproperty
  property p_range;
    div_valid && frac_active && $past(frac_active, 2) |->
      div_ratio >= 20'h00014 && div_ratio <= 20'h7FFFD;
  endproperty
  property p_exact_sub;
    exact_active |-> frac_active;
  endproperty
  property p_err_sub;
    ratio_err |-> frac_active;
  endproperty
  property p_unmapped;
    !(reg_addr inside {5'h03, 5'h04, 5'h06, 5'h0C, 5'h10, 5'h11}) |=> reg_rdata == 24'h0;
  endproperty
  a_frac_on: assert property (p_frac_on) else $error("frac mode not entered");
  a_frac_off: assert property (p_frac_off) else $error("frac mode not left");
  a_int_valid: assert property (p_int_valid) else $error("int valid late");
  a_frac_valid: assert property (p_frac_valid) else $error("frac valid late");
  a_valid_cause: assert property (p_valid_cause) else $error("valid without tick");
  a_range: assert property (p_range) else $error("ratio out of range");
  a_exact_sub: assert property (p_exact_sub) else $error("exact outside frac");
  a_err_sub: assert property (p_err_sub) else $error("error outside frac");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
endmodule : efm_check

// ==== tb/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pd_tick = 1'b0;
  logic reg_we = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [23:0] reg_wdata = 24'h000000;
  logic [23:0] reg_rdata;
  logic [19:0] div_ratio;
  logic div_valid, frac_active, exact_active, ratio_err;
  int err_total = 0;
  int n_compared = 0;
  int sum;
  logic [23:0] got;
  efm_top efm_top_inst (.clk, .rstn, .pd_tick, .reg_we, .reg_addr, .reg_wdata, .reg_rdata,
    .div_ratio, .div_valid, .frac_active, .exact_active, .ratio_err);
  always #20 clk = ~clk;
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(posedge clk) #1;
    reg_we = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_we = 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [23:0] exp);
    @(posedge clk) #1;
    reg_addr = a;
    @(posedge clk) #1;
    chk(reg_rdata, exp);
  endtask : rd
  // Bounded wait: frac mode answers one cycle later than int mode
  task automatic tick(output logic [23:0] r);
    int k;
    @(posedge clk) #1;
    pd_tick = 1'b1;
    @(posedge clk) #1;
    pd_tick = 1'b0;
    for (k = 0; k < 4 && div_valid !== 1'b1; k++) @(posedge clk) #1;
    r = {4'h0, div_ratio};
  endtask : tick
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  initial
  begin
    #(40 * 40000);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    rd(5'h03, 24'h000014);
    rd(5'h04, 24'h000000);
    rd(5'h0C, 24'h000000);
    $display("test reset done");
    wr(5'h03, 24'hFFFFFF);
    rd(5'h03, 24'h07FFFF);
    tick(got);
    chk(got, 24'h07FFFF);
    wr(5'h03, 24'h000038);
    tick(got);
    chk(got, 24'h000038);
    wr(5'h05, 24'h123456);
    rd(5'h05, 24'h000000);
    $display("test integer done");
    wr(5'h06, 24'h000801);
    tick(got);
    chk(24'(frac_active), 24'h1);
    rd(5'h11, 24'h800000);
    wr(5'h04, 24'h800000);
    wr(5'h06, 24'h000800);
    tick(got);
    sum = 0;
    repeat (4)
    begin
      tick(got);
      sum += int'(got) - 56;
    end
    chk(24'(sum), 24'h2);
    $display("test binary fraction done");
    wr(5'h03, 24'h00002D);
    wr(5'h04, 24'h93EAAB);
    wr(5'h0C, 24'h000C00);
    tick(got);
    chk(24'(exact_active), 24'h1);
    sum = 0;
    repeat (3072)
    begin
      tick(got);
      sum += int'(got) - 45;
    end
    chk(24'(sum), 24'd1775);
    wr(5'h04, 24'h938000);
    tick(got);
    sum = 0;
    repeat (512)
    begin
      tick(got);
      sum += int'(got) - 45;
    end
    chk(24'(sum), 24'd295);
    $display("test exact done");
    wr(5'h04, 24'h000000);
    wr(5'h0C, 24'h000000);
    wr(5'h03, 24'h000010);
    tick(got);
    chk(24'(ratio_err), 24'h1);
    chk(24'(exact_active), 24'h0);
    tick(got);
    chk(got, 24'h000014);
    wr(5'h03, 24'h07FFFF);
    tick(got);
    tick(got);
    chk(got, 24'h07FFFC);
    wr(5'h0C, 24'hFFFFFF);
    rd(5'h0C, 24'h003FFF);
    wr(5'h06, 24'h000880);
    tick(got);
    chk(24'(frac_active), 24'h0);
    $display("test limits done");
    conclude();
  end
endmodule : testbench
bind efm_top efm_check efm_check_inst (.clk, .rstn, .pd_tick, .reg_we, .reg_addr, .reg_wdata,
  .reg_rdata, .div_ratio, .div_valid, .frac_active, .exact_active, .ratio_err);
